// file: common/byte_cpu_regs.svh
`ifndef BYTE_CPU_REGS_SVH
`define BYTE_CPU_REGS_SVH

// instruction length in program bytes
`define LEN_1 2'h1
`define LEN_2 2'h2
`define LEN_3 2'h3

// cycle figures; zero means "as many cycles as bytes"
`define CYC_BY_LEN        4'h0
`define CYC_INDIRECT      4'h2
`define CYC_MUL           4'h4
`define CYC_DIV           4'h8
`define CYC_EXT_MOVE      4'h3
`define CYC_CODE_READ     4'h3
`define CYC_ABS_BRANCH    4'h4
`define CYC_LONG_BRANCH   4'h5
`define CYC_RETURN        4'h6
`define CYC_JMP_INDIRECT  4'h4
`define CYC_CJNE_MEM      4'h4
`define BRANCH_TAKEN_EXTRA 4'h1

// flag effect mask, bit 2 carry, bit 1 aux carry, bit 0 overflow
`define FX_NONE  3'h0
`define FX_CY    3'h4
`define FX_CY_OV 3'h5
`define FX_ALL   3'h7

// opcodes that touch the data pointer, then pointer and operand reset values
`define OP_LOAD_DP16 8'h90
`define OP_INC_DP16  8'hA3
`define DP16_RESET   16'h0000
`define OPERAND_RESET 8'h00

`endif

// file: common/byte_cpu_pkg.sv
package byte_cpu_pkg;

    typedef enum logic [3:0] {
        cls_nop,
        cls_arith,
        cls_logic,
        cls_rotate,
        cls_move,
        cls_code_read,
        cls_ext_data,
        cls_stack,
        cls_exchange,
        cls_bit,
        cls_muldiv,
        cls_branch,
        cls_cond_branch
    } instr_class_e;

    typedef struct packed {
        instr_class_e cls;
        logic [1:0]   len;
        logic [3:0]   cyc;
        logic         cond;
        logic [2:0]   flags;
    } decode_s;

endpackage : byte_cpu_pkg

// file: common/decode_if.sv
interface decode_if;
    logic [1:0] len;
    logic [3:0] cyc;
    logic       cond;
    logic       start;
    logic       busy;
    logic       last;
    logic       fetch;
    logic [1:0] byte_index;

    modport decoder (output len, cyc, cond, start,
                     input busy, last, fetch, byte_index);
    modport sequencer (input len, cyc, cond, start,
                       output busy, last, fetch, byte_index);
    modport collector (input fetch, byte_index);
endinterface : decode_if

// file: rtl/cycle_sequencer.sv
`include "byte_cpu_regs.svh"

module cycle_sequencer
    import byte_cpu_pkg::*;
(
    // clock and reset
    input  wire logic clock_in,
    input  wire logic srst_in,
    // decoded instruction and pacing
    decode_if.sequencer dec,
    // condition result of a conditional branch
    input  wire logic branch_taken_in
);
    logic       busy;
    logic [3:0] remain;
    logic [1:0] idx;
    logic [1:0] len_q;
    logic       cond_q;
    logic       extended;
    logic       at_end;
    logic       take_extra;

    // a taken branch stretches the instruction by one cycle, once
    assign at_end     = busy && (remain == 4'h1);
    assign take_extra = at_end && cond_q && !extended && branch_taken_in;
    assign dec.busy   = busy;
    assign dec.last   = at_end && !take_extra;
    // operand bytes follow the opcode, one per cycle
    assign dec.fetch  = busy && ((idx + 2'h1) < len_q);
    assign dec.byte_index = idx + 2'h1;

    // busy flag; a new start in the last cycle runs back to back
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            busy <= 1'b0;
        end else if (dec.start) begin
            busy <= 1'b1;
        end else if (dec.last) begin
            busy <= 1'b0;
        end
    end

    // cycle countdown, counted in plain clocks only
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            remain   <= 4'h0;
            extended <= 1'b0;
        end else if (dec.start) begin
            remain   <= dec.cyc;
            extended <= 1'b0;
        end else if (take_extra) begin
            remain   <= `BRANCH_TAKEN_EXTRA;
            extended <= 1'b1;
        end else if (busy) begin
            remain <= remain - 4'h1;
        end
    end

    // byte position and latched shape of the running instruction
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            idx    <= 2'h0;
            len_q  <= `LEN_1;
            cond_q <= 1'b0;
        end else if (dec.start) begin
            idx    <= 2'h0;
            len_q  <= dec.len;
            cond_q <= dec.cond;
        end else if (dec.fetch) begin
            idx <= idx + 2'h1;
        end
    end
endmodule : cycle_sequencer

// file: rtl/operand_collector.sv
`include "byte_cpu_regs.svh"

module operand_collector
    import byte_cpu_pkg::*;
(
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       srst_in,
    // fetch pacing
    decode_if.collector     dec,
    // program memory byte, valid while fetch is high
    input  wire logic [7:0] code_byte_in,
    // captured in-line operands
    output logic      [7:0] operand1_out,
    output logic      [7:0] operand2_out
);
    // each operand stays until overwritten by a later fetch of its own byte position
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            operand1_out <= `OPERAND_RESET;
            operand2_out <= `OPERAND_RESET;
        end else if (dec.fetch && dec.byte_index == 2'h1) begin
            operand1_out <= code_byte_in;
        end else if (dec.fetch && dec.byte_index == 2'h2) begin
            operand2_out <= code_byte_in;
        end
    end
endmodule : operand_collector

// file: rtl/byte_cpu_instruction_timing.sv
`include "byte_cpu_regs.svh"

module byte_cpu_instruction_timing
    import byte_cpu_pkg::*;
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    // opcode handshake from program memory
    input  wire logic [7:0]  opcode_in,
    input  wire logic        opcode_valid_in,
    output logic             opcode_ready_out,
    // operand byte fetch from program memory
    output logic             code_fetch_out,
    input  wire logic [7:0]  code_byte_in,
    // branch condition from the execution unit
    input  wire logic        branch_taken_in,
    // decoded instruction, held for the whole instruction; operands held from the cycle after their fetch
    output instr_class_e     instr_class_out,
    output logic [1:0]       byte_count_out,
    output logic [3:0]       base_cycles_out,
    output logic             conditional_out,
    output logic [2:0]       flag_effect_out,
    output logic [7:0]       operand1_out,
    output logic [7:0]       operand2_out,
    // completion and architectural state
    output logic             done_out,
    output logic [15:0]      data_pointer_16_out
);
    decode_if dec ();

    decode_s    decoded;
    logic [7:0] opcode_q;
    logic       accept;

    // build one table entry
    function automatic decode_s mk(input instr_class_e cls,
                                   input logic [1:0] len,
                                   input logic [3:0] cyc,
                                   input logic cond,
                                   input logic [2:0] flags);
        decode_s d;
        d.cls   = cls;
        d.len   = len;
        d.cyc   = cyc;
        d.cond  = cond;
        d.flags = flags;
        return d;
    endfunction : mk

    // full opcode table; entries with no cycle figure run one per byte
    function automatic decode_s decode_opcode(input logic [7:0] op);
        decode_s    d;
        logic [3:0] row;
        logic [3:0] col;
        d   = mk(cls_nop, `LEN_1, `CYC_BY_LEN, 1'b0, `FX_NONE);
        row = op[7:4];
        col = op[3:0];
        if (col[3]) begin
            // working register column
            unique case (row)
            4'h0: d = mk(cls_arith, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            4'h1: d = mk(cls_arith, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            4'h2: d = mk(cls_arith, `LEN_1, 4'h0, 1'b0, `FX_ALL);
            4'h3: d = mk(cls_arith, `LEN_1, 4'h0, 1'b0, `FX_ALL);
            4'h4: d = mk(cls_logic, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            4'h5: d = mk(cls_logic, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            4'h6: d = mk(cls_logic, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            4'h7: d = mk(cls_move, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'h8: d = mk(cls_move, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'h9: d = mk(cls_arith, `LEN_1, 4'h0, 1'b0, `FX_ALL);
            4'hA: d = mk(cls_move, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'hB: d = mk(cls_cond_branch, `LEN_3, 4'h0, 1'b1, `FX_CY);
            4'hC: d = mk(cls_exchange, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            4'hD: d = mk(cls_cond_branch, `LEN_2, 4'h0, 1'b1, `FX_NONE);
            4'hE: d = mk(cls_move, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            4'hF: d = mk(cls_move, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            endcase
        end else if (col[3:1] == 3'h3) begin
            // indirect RAM column: the pointer read costs a cycle, except in the two-byte moves of rows 7, 8 and A
            unique case (row)
            4'h0: d = mk(cls_arith, `LEN_1, `CYC_INDIRECT, 1'b0, `FX_NONE);
            4'h1: d = mk(cls_arith, `LEN_1, `CYC_INDIRECT, 1'b0, `FX_NONE);
            4'h2: d = mk(cls_arith, `LEN_1, `CYC_INDIRECT, 1'b0,
                         `FX_ALL);
            4'h3: d = mk(cls_arith, `LEN_1, `CYC_INDIRECT, 1'b0,
                         `FX_ALL);
            4'h4: d = mk(cls_logic, `LEN_1, `CYC_INDIRECT, 1'b0,
                         `FX_NONE);
            4'h5: d = mk(cls_logic, `LEN_1, `CYC_INDIRECT, 1'b0,
                         `FX_NONE);
            4'h6: d = mk(cls_logic, `LEN_1, `CYC_INDIRECT, 1'b0,
                         `FX_NONE);
            4'h7: d = mk(cls_move, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'h8: d = mk(cls_move, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'h9: d = mk(cls_arith, `LEN_1, `CYC_INDIRECT, 1'b0,
                         `FX_ALL);
            4'hA: d = mk(cls_move, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'hB: d = mk(cls_cond_branch, `LEN_3, `CYC_CJNE_MEM, 1'b1,
                         `FX_CY);
            4'hC: d = mk(cls_exchange, `LEN_1, `CYC_INDIRECT, 1'b0,
                         `FX_NONE);
            4'hD: d = mk(cls_exchange, `LEN_1, `CYC_INDIRECT, 1'b0,
                         `FX_NONE);
            4'hE: d = mk(cls_move, `LEN_1, `CYC_INDIRECT, 1'b0, `FX_NONE);
            4'hF: d = mk(cls_move, `LEN_1, `CYC_INDIRECT, 1'b0,
                         `FX_NONE);
            endcase
        end else if (col == 4'h5) begin
            // direct byte column
            unique case (row)
            4'h0: d = mk(cls_arith, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'h1: d = mk(cls_arith, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'h2: d = mk(cls_arith, `LEN_2, 4'h0, 1'b0, `FX_ALL);
            4'h3: d = mk(cls_arith, `LEN_2, 4'h0, 1'b0, `FX_ALL);
            4'h4: d = mk(cls_logic, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'h5: d = mk(cls_logic, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'h6: d = mk(cls_logic, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'h7: d = mk(cls_move, `LEN_3, 4'h0, 1'b0, `FX_NONE);
            4'h8: d = mk(cls_move, `LEN_3, 4'h0, 1'b0, `FX_NONE);
            4'h9: d = mk(cls_arith, `LEN_2, 4'h0, 1'b0, `FX_ALL);
            4'hA: d = mk(cls_nop, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            4'hB: d = mk(cls_cond_branch, `LEN_3, `CYC_CJNE_MEM, 1'b1,
                         `FX_CY);
            4'hC: d = mk(cls_exchange, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'hD: d = mk(cls_cond_branch, `LEN_3, 4'h0, 1'b1, `FX_NONE);
            4'hE: d = mk(cls_move, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'hF: d = mk(cls_move, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            endcase
        end else if (col == 4'h4) begin
            // accumulator and immediate column
            unique case (row)
            4'h0: d = mk(cls_arith, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            4'h1: d = mk(cls_arith, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            4'h2: d = mk(cls_arith, `LEN_2, 4'h0, 1'b0, `FX_ALL);
            4'h3: d = mk(cls_arith, `LEN_2, 4'h0, 1'b0, `FX_ALL);
            4'h4: d = mk(cls_logic, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'h5: d = mk(cls_logic, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'h6: d = mk(cls_logic, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'h7: d = mk(cls_move, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'h8: d = mk(cls_muldiv, `LEN_1, `CYC_DIV, 1'b0,
                         `FX_CY_OV);
            4'h9: d = mk(cls_arith, `LEN_2, 4'h0, 1'b0, `FX_ALL);
            4'hA: d = mk(cls_muldiv, `LEN_1, `CYC_MUL, 1'b0,
                         `FX_CY_OV);
            4'hB: d = mk(cls_cond_branch, `LEN_3, 4'h0, 1'b1, `FX_CY);
            4'hC: d = mk(cls_rotate, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            4'hD: d = mk(cls_arith, `LEN_1, 4'h0, 1'b0, `FX_CY);
            4'hE: d = mk(cls_logic, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            4'hF: d = mk(cls_logic, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            endcase
        end else if (col == 4'h3) begin
            // rotates, logic to direct, code reads and carry ops
            unique case (row)
            4'h0: d = mk(cls_rotate, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            4'h1: d = mk(cls_rotate, `LEN_1, 4'h0, 1'b0, `FX_CY);
            4'h2: d = mk(cls_rotate, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            4'h3: d = mk(cls_rotate, `LEN_1, 4'h0, 1'b0, `FX_CY);
            4'h4: d = mk(cls_logic, `LEN_3, 4'h0, 1'b0, `FX_NONE);
            4'h5: d = mk(cls_logic, `LEN_3, 4'h0, 1'b0, `FX_NONE);
            4'h6: d = mk(cls_logic, `LEN_3, 4'h0, 1'b0, `FX_NONE);
            4'h7: d = mk(cls_branch, `LEN_1, `CYC_JMP_INDIRECT, 1'b0,
                         `FX_NONE);
            4'h8: d = mk(cls_code_read, `LEN_1, `CYC_CODE_READ, 1'b0,
                         `FX_NONE);
            4'h9: d = mk(cls_code_read, `LEN_1, `CYC_CODE_READ, 1'b0,
                         `FX_NONE);
            4'hA: d = mk(cls_arith, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            4'hB: d = mk(cls_bit, `LEN_1, 4'h0, 1'b0, `FX_CY);
            4'hC: d = mk(cls_bit, `LEN_1, 4'h0, 1'b0, `FX_CY);
            4'hD: d = mk(cls_bit, `LEN_1, 4'h0, 1'b0, `FX_CY);
            4'hE: d = mk(cls_ext_data, `LEN_1, `CYC_EXT_MOVE, 1'b0,
                         `FX_NONE);
            4'hF: d = mk(cls_ext_data, `LEN_1, `CYC_EXT_MOVE, 1'b0,
                         `FX_NONE);
            endcase
        end else if (col == 4'h2) begin
            // long branches, logic from accumulator and bit ops
            unique case (row)
            4'h0: d = mk(cls_branch, `LEN_3, `CYC_LONG_BRANCH, 1'b0,
                         `FX_NONE);
            4'h1: d = mk(cls_branch, `LEN_3, `CYC_LONG_BRANCH, 1'b0,
                         `FX_NONE);
            4'h2: d = mk(cls_branch, `LEN_1, `CYC_RETURN, 1'b0, `FX_NONE);
            4'h3: d = mk(cls_branch, `LEN_1, `CYC_RETURN, 1'b0, `FX_NONE);
            4'h4: d = mk(cls_logic, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'h5: d = mk(cls_logic, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'h6: d = mk(cls_logic, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'h7: d = mk(cls_bit, `LEN_2, 4'h0, 1'b0, `FX_CY);
            4'h8: d = mk(cls_bit, `LEN_2, 4'h0, 1'b0, `FX_CY);
            4'h9: d = mk(cls_bit, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'hA: d = mk(cls_bit, `LEN_2, 4'h0, 1'b0, `FX_CY);
            4'hB: d = mk(cls_bit, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'hC: d = mk(cls_bit, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'hD: d = mk(cls_bit, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'hE: d = mk(cls_ext_data, `LEN_1, `CYC_EXT_MOVE, 1'b0,
                         `FX_NONE);
            4'hF: d = mk(cls_ext_data, `LEN_1, `CYC_EXT_MOVE, 1'b0,
                         `FX_NONE);
            endcase
        end else if (col == 4'h1) begin
            // absolute jump and call, odd rows call
            d = mk(cls_branch, `LEN_2, `CYC_ABS_BRANCH, 1'b0, `FX_NONE);
        end else begin
            // column zero: bit branches, stack, pointer load
            unique case (row)
            4'h0: d = mk(cls_nop, `LEN_1, 4'h0, 1'b0, `FX_NONE);
            4'h1: d = mk(cls_cond_branch, `LEN_3, 4'h0, 1'b1, `FX_NONE);
            4'h2: d = mk(cls_cond_branch, `LEN_3, 4'h0, 1'b1, `FX_NONE);
            4'h3: d = mk(cls_cond_branch, `LEN_3, 4'h0, 1'b1, `FX_NONE);
            4'h4: d = mk(cls_cond_branch, `LEN_2, 4'h0, 1'b1, `FX_NONE);
            4'h5: d = mk(cls_cond_branch, `LEN_2, 4'h0, 1'b1, `FX_NONE);
            4'h6: d = mk(cls_cond_branch, `LEN_2, 4'h0, 1'b1, `FX_NONE);
            4'h7: d = mk(cls_cond_branch, `LEN_2, 4'h0, 1'b1, `FX_NONE);
            4'h8: d = mk(cls_branch, `LEN_2, `CYC_ABS_BRANCH, 1'b0,
                         `FX_NONE);
            4'h9: d = mk(cls_move, `LEN_3, 4'h0, 1'b0, `FX_NONE);
            4'hA: d = mk(cls_bit, `LEN_2, 4'h0, 1'b0, `FX_CY);
            4'hB: d = mk(cls_bit, `LEN_2, 4'h0, 1'b0, `FX_CY);
            4'hC: d = mk(cls_stack, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'hD: d = mk(cls_stack, `LEN_2, 4'h0, 1'b0, `FX_NONE);
            4'hE: d = mk(cls_ext_data, `LEN_1, `CYC_EXT_MOVE, 1'b0,
                         `FX_NONE);
            4'hF: d = mk(cls_ext_data, `LEN_1, `CYC_EXT_MOVE, 1'b0,
                         `FX_NONE);
            endcase
        end
        // pipeline default: one cycle per program byte
        if (d.cyc == `CYC_BY_LEN) begin
            d.cyc = {2'h0, d.len};
        end
        return d;
    endfunction : decode_opcode

    // decode straight off the program memory byte
    assign decoded = decode_opcode(opcode_in);

    // a new opcode is taken when idle or in the final cycle
    assign opcode_ready_out = !dec.busy || dec.last;
    assign accept           = opcode_valid_in && opcode_ready_out;
    assign dec.start        = accept;
    assign dec.len          = decoded.len;
    assign dec.cyc          = decoded.cyc;
    assign dec.cond         = decoded.cond;
    assign code_fetch_out   = dec.fetch;
    assign done_out         = dec.last;

    cycle_sequencer u_sequencer (
        .clock_in        (clock_in),
        .srst_in         (srst_in),
        .dec             (dec.sequencer),
        .branch_taken_in (branch_taken_in)
    );

    operand_collector u_collector (
        .clock_in     (clock_in),
        .srst_in      (srst_in),
        .dec          (dec.collector),
        .code_byte_in (code_byte_in),
        .operand1_out (operand1_out),
        .operand2_out (operand2_out)
    );

    // decoded fields held from the accept edge to the next accept
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            opcode_q        <= 8'h00;
            instr_class_out <= cls_nop;
            byte_count_out  <= `LEN_1;
            base_cycles_out <= 4'h1;
            conditional_out <= 1'b0;
            flag_effect_out <= `FX_NONE;
        end else if (accept) begin
            opcode_q        <= opcode_in;
            instr_class_out <= decoded.cls;
            byte_count_out  <= decoded.len;
            base_cycles_out <= decoded.cyc;
            conditional_out <= decoded.cond;
            flag_effect_out <= decoded.flags;
        end
    end

    // data pointer: updated only at the end so a stalled load is harmless
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            data_pointer_16_out <= `DP16_RESET;
        end else if (dec.last && opcode_q == `OP_LOAD_DP16) begin
            data_pointer_16_out <= {operand1_out, operand2_out};
        end else if (dec.last && opcode_q == `OP_INC_DP16) begin
            data_pointer_16_out <= data_pointer_16_out + 16'h0001;
        end
    end
endmodule : byte_cpu_instruction_timing

// file: verification/code_mem_model.sv
module code_mem_model (
    // clock and fetch request
    input  wire logic       clock_in,
    input  wire logic       fetch_in,
    // operand byte toward the core
    output logic      [7:0] code_byte_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] lfsr = 8'h5A;
    logic [7:0] last = 8'h00;
    // byte shown only while fetched; idle bus flips so stale captures fail
    assign code_byte_out = fetch_in ? lfsr : ~last;
    // new pseudo-random byte after each fetched one
    always_ff @(posedge clock_in) begin
        if (fetch_in) begin
            last <= lfsr;
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        end
    end
endmodule : code_mem_model

// file: verification/byte_cpu_instruction_timing_chk.sv
module byte_cpu_instruction_timing_chk (
    // clock and reset
    input wire logic        clock_in,
    input wire logic        srst_in,
    // handshake and fetch
    input wire logic [7:0]  opcode_in,
    input wire logic        opcode_valid_in,
    input wire logic        opcode_ready_out,
    input wire logic        code_fetch_out,
    input wire logic        branch_taken_in,
    // decoded view and state
    input wire logic [1:0]  byte_count_out,
    input wire logic [3:0]  base_cycles_out,
    input wire logic        conditional_out,
    input wire logic [7:0]  operand1_out,
    input wire logic [7:0]  operand2_out,
    input wire logic        done_out,
    input wire logic [15:0] data_pointer_16_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);
    // an opcode is taken on this edge
    wire logic acc = opcode_valid_in && opcode_ready_out;

    property p_done_ready; done_out |-> opcode_ready_out; endproperty
    a_done_ready: assert property (p_done_ready)
        else $error("done not ready");
    property p_fetch_busy; code_fetch_out |-> !opcode_ready_out; endproperty
    a_fetch_busy: assert property (p_fetch_busy)
        else $error("fetch at end");
    property p_one; acc ##1 base_cycles_out == 4'h1 |-> done_out; endproperty
    a_one: assert property (p_one)
        else $error("single cycle op late");
    property p_two;
        acc ##1 base_cycles_out == 4'h2 && !conditional_out |->
            !done_out ##1 done_out;
    endproperty
    a_two: assert property (p_two) else $error("two cycle op wrong");
    property p_div;
        acc ##1 base_cycles_out == 4'h8 |->
            !done_out [*7] ##1 done_out;
    endproperty
    a_div: assert property (p_div)
        else $error("eight cycle op wrong");
    property p_fetch3;
        acc ##1 byte_count_out == 2'h3 |->
            code_fetch_out [*2] ##1 !code_fetch_out;
    endproperty
    a_fetch3: assert property (p_fetch3)
        else $error("three byte fetch");
    property p_taken;
        acc ##1 conditional_out && base_cycles_out == 4'h2 ##1 branch_taken_in
            |-> !done_out ##1 done_out;
    endproperty
    a_taken: assert property (p_taken)
        else $error("taken branch length");
    property p_dp_load;
        acc && opcode_in == 8'h90 |->
            ##4 data_pointer_16_out == {operand1_out, operand2_out};
    endproperty
    a_dp_load: assert property (p_dp_load)
        else $error("pointer load");
endmodule : byte_cpu_instruction_timing_chk

bind byte_cpu_instruction_timing byte_cpu_instruction_timing_chk u_chk (
    .clock_in, .srst_in, .opcode_in, .opcode_valid_in, .opcode_ready_out,
    .code_fetch_out, .branch_taken_in, .byte_count_out, .base_cycles_out,
    .conditional_out, .operand1_out, .operand2_out, .done_out,
    .data_pointer_16_out);

// file: verification/testbench.sv
module testbench
    import byte_cpu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clock_in = 1'b0;
    logic         srst_in  = 1'b1;
    logic         valid    = 1'b0;
    logic         taken    = 1'b0;
    logic [7:0]   opcode   = 8'h00;
    logic [7:0]   code_byte, op1, op2;
    logic         ready, fetch, cond, done;
    logic [1:0]   nbytes;
    logic [3:0]   ncyc;
    logic [2:0]   flags;
    logic [15:0]  dp, exp_dp = 16'h0000;
    instr_class_e cls;
    int           n_fail = 0, cmp_count = 0;
    logic [20:0]  q [$];
    // opcode, bytes, cycles, flag mask (carry, aux carry, overflow)
    logic [19:0]  tbl [42] = '{
        20'h28117, 20'h38117, 20'h98117, 20'h26127,
        20'h25227, 20'h24227, 20'h34227, 20'h53330,
        20'h43330, 20'h63330, 20'h52220, 20'h56120,
        20'h23110, 20'h33114, 20'h03110, 20'h13114,
        20'h85330, 20'h90330, 20'h93130, 20'h83130,
        20'hE2130, 20'hF2130, 20'hE0130, 20'hF0130,
        20'hC0220, 20'hD0220, 20'hF6120, 20'h76220,
        20'hD6120, 20'h88220, 20'hA4145, 20'h84185,
        20'hC3114, 20'hD3114, 20'hB3114, 20'hC2220,
        20'hD2220, 20'hB2220, 20'h40220, 20'h50220,
        20'hA5110, 20'hA3110};

    always #20 clock_in = ~clock_in;

    byte_cpu_instruction_timing u_dut (
        .clock_in, .srst_in, .opcode_in(opcode), .opcode_valid_in(valid),
        .opcode_ready_out(ready), .code_fetch_out(fetch),
        .code_byte_in(code_byte), .branch_taken_in(taken),
        .instr_class_out(cls), .byte_count_out(nbytes),
        .base_cycles_out(ncyc), .conditional_out(cond),
        .flag_effect_out(flags), .operand1_out(op1), .operand2_out(op2),
        .done_out(done), .data_pointer_16_out(dp));
    code_mem_model u_mem (.clock_in, .fetch_in(fetch),
        .code_byte_out(code_byte));

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // a taken conditional runs one cycle past its not-taken length
    function automatic logic [15:0] exp_cyc(logic [20:0] e);
        logic br;
        br = e[20:13] == 8'h40 || e[20:13] == 8'h50;
        return 16'(e[8:5]) + 16'(br && e[0]);
    endfunction : exp_cyc

    // next opcode waits on the bus, refused until the done cycle
    task automatic run_op(logic [20:0] e, logic [7:0] nxt);
        int         cyc;
        int         nf;
        logic [7:0] e1;
        logic [7:0] e2;
        logic       br;
        cyc = 0;
        br = e[20:13] inside {8'h40, 8'h50};
        nf = 0;
        while (ready !== 1'b1) @(negedge clock_in);
        @(posedge clock_in);
        opcode <= nxt;
        taken <= e[0];
        do begin
            @(negedge clock_in);
            if (fetch && nf == 0) e1 = code_byte;
            if (fetch && nf == 1) e2 = code_byte;
            nf += int'(fetch);
            cyc++;
        end while (done !== 1'b1 && cyc < 20);
        check("cycles", exp_cyc(e), 16'(cyc));
        check("fetches", 16'(e[12:9]) - 16'h1, 16'(nf));
        check("bytes", 16'(e[10:9]), 16'(nbytes));
        check("base cycles", 16'(e[8:5]), 16'(ncyc));
        check("flags", 16'(e[3:1]), 16'(flags));
        check("conditional", 16'(br), 16'(cond));
        // class spot checks where the kind of opcode is fixed
        if (br) check("class", 16'(cls_cond_branch), 16'(cls));
        if (e[20:13] == 8'hA5) check("class", 16'(cls_nop), 16'(cls));
        if (e[20:13] inside {8'hA4, 8'h84})
            check("class", 16'(cls_muldiv), 16'(cls));
        if (nf > 0) check("operand1", 16'(e1), 16'(op1));
        if (nf > 1) check("operand2", 16'(e2), 16'(op2));
        check("pointer", exp_dp, dp);
        if (e[20:13] == 8'h90) exp_dp = {e1, e2};
        if (e[20:13] == 8'hA3) exp_dp++;
    endtask : run_op

    // every code once, both branch outcomes, then random traffic
    initial begin
        void'($urandom(10));
        foreach (tbl[i]) q.push_back({tbl[i], 1'b1});
        q.push_back({20'h40220, 1'b0});
        q.push_back({20'h50220, 1'b0});
        repeat (300) q.push_back({tbl[$urandom_range(41)], 1'($urandom)});
        repeat (10) @(posedge clock_in);
        srst_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        opcode <= q[0][20:13];
        valid <= 1'b1;
        @(negedge clock_in);
        check("reset pointer", 16'h0000, dp);
        check("reset class", 16'(cls_nop), 16'(cls));
        check("reset conditional", 16'h0000, 16'(cond));
        foreach (q[i]) begin
            run_op(q[i], i + 1 < q.size() ? q[i + 1][20:13] : 8'hA5);
        end
        end_of_test();
    end

    // hang guard, well past the longest expected run
    initial begin
        #(10000 * 40);
        n_fail++;
        end_of_test();
    end
endmodule : testbench
